// *** core/bsd_sinc3_host.sv ***
// Host end: makes the modulator clock and runs a sinc3 decimator.
// Assumes the returned bit is an unsynchronised pin.
`timescale 1ns/1ps

// Two-flop synchroniser for the stream pin
module bsd_host_sync
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_pin,
   output logic o_pin_sync
);
   logic stage1;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage1 <= 1'b0;
         o_pin_sync <= 1'b0;
      end else begin
         stage1 <= i_pin;
         o_pin_sync <= stage1;
      end
   end
endmodule // bsd_host_sync

// One integrator stage, advanced once per modulator bit
module bsd_integ_stage
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_step,
   input wire logic [SINC_W-1:0] i_in,
   output logic [SINC_W-1:0] o_sum
);
   // Wraps modulo 2^SINC_W; the comb differences undo it
   wire logic [SINC_W-1:0] next_sum = o_sum + i_in;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sum <= '0;
      end else if (i_step) begin
         o_sum <= next_sum; // R15
      end
   end
endmodule // bsd_integ_stage

// One comb stage, advanced once per output word
module bsd_comb_stage
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_step,
   input wire logic [SINC_W-1:0] i_in,
   output logic [SINC_W-1:0] o_diff
);
   logic [SINC_W-1:0] held;

   // Difference against the value held at the previous word
   assign o_diff = i_in - held;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         held <= '0;
      end else if (i_step) begin
         held <= i_in; // R15
      end
   end
endmodule // bsd_comb_stage

// Divider: bit enable once per MOD_DIV cycles and the clock pin level
module bsd_clk_div
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   output logic o_capture,
   output logic o_mod_clk
);
   logic [DIV_W-1:0] div_cnt;
   wire logic [DIV_W-1:0] next_div_cnt = div_cnt + 1'b1;
   // Clock starts only at a bit enable, so its first high phase is full length
   wire next_mod_clk = ~next_div_cnt[DIV_W-1] & (o_capture | o_mod_clk); // R2 R13

   // Rising edge of the modulator clock happens on this enable
   assign o_capture = (div_cnt == DIV_LAST); // R12 R13

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_cnt <= '0;
         o_mod_clk <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         o_mod_clk <= next_mod_clk; // R2
      end
   end
endmodule // bsd_clk_div

module bsd_sinc3_host
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   output logic [WORD_W-1:0] o_word,
   output logic o_word_valid,
   bsd_link_if.host link
);
   logic capture;
   logic mod_clk;
   logic bit_sync;
   logic [DEC_CNT_W-1:0] dec_cnt;
   logic [SINC_W-1:0] int1;
   logic [SINC_W-1:0] int2;
   logic [SINC_W-1:0] int3;
   logic [SINC_W-1:0] comb1;
   logic [SINC_W-1:0] comb2;
   logic [SINC_W-1:0] comb3;

   wire dec_done = capture && (dec_cnt == DEC_LAST); // R9
   wire logic [DEC_CNT_W-1:0] next_dec_cnt = dec_cnt + 1'b1;
   wire logic [SINC_W-1:0] bit_in = {{(SINC_W-1){1'b0}}, bit_sync};
   // All ones reaches 2^24; clip to the top code
   wire logic [WORD_W-1:0] word_c = comb3[SINC_W-1] ? WORD_MAX :
      comb3[DATA_SIZE-1:WORD_LSB]; // R14 R10 R11

   bsd_clk_div i_bsd_clk_div (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .o_capture(capture),
      .o_mod_clk(mod_clk)
   );

   bsd_host_sync i_bsd_host_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_pin(link.modulator_bit_out),
      .o_pin_sync(bit_sync)
   );

   // Integrators run on every captured bit
   bsd_integ_stage i_bsd_integ_stage_1 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(capture),
      .i_in(bit_in),
      .o_sum(int1)
   ); // R7 R15

   bsd_integ_stage i_bsd_integ_stage_2 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(capture),
      .i_in(int1),
      .o_sum(int2)
   ); // R15

   bsd_integ_stage i_bsd_integ_stage_3 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(capture),
      .i_in(int2),
      .o_sum(int3)
   ); // R15

   // Combs run once per word on the last integrator
   bsd_comb_stage i_bsd_comb_stage_1 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(dec_done),
      .i_in(int3),
      .o_diff(comb1)
   ); // R8

   bsd_comb_stage i_bsd_comb_stage_2 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(dec_done),
      .i_in(comb1),
      .o_diff(comb2)
   ); // R15

   bsd_comb_stage i_bsd_comb_stage_3 (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_step(dec_done),
      .i_in(comb2),
      .o_diff(comb3)
   ); // R15

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dec_cnt <= '0;
      end else if (capture) begin
         dec_cnt <= next_dec_cnt;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_word <= WORD_MID;
         o_word_valid <= 1'b0;
      end else begin
         o_word_valid <= dec_done; // R9
         if (dec_done) begin
            o_word <= word_c;
         end
      end
   end

   assign link.modulator_clock_in = mod_clk;
endmodule // bsd_sinc3_host

// *** core/bsd_pkg.sv ***
// Shared constants for the single-bit stream link and its sinc3 receiver.
// Assumes one 40 MHz system clock on both ends and an active-low async reset.
// What this block does
// R1 - Emit bit stream, ones density tracks input
// R2 - Host supplies modulator clock, device makes none
// R3 - Zero input gives half ones
// R4 - Positive specified limit gives 89.06 percent ones
// R5 - Negative specified limit gives 10.94 percent ones
// R6 - Full scale gives all ones or zeros
// R7 - Receiver filters and decimates the stream
// R8 - Receiver uses third-order sinc filter
// R9 - Ratio 256 gives 16-bit words
// R10 - Specified limits map to 7168 and 58368
// R11 - Zero input maps to midscale 32768
// R12 - Launch on rising edge, capture next
// R13 - Modulator clock between 5 and 21 MHz
// R14 - Result is top 16 of 24 bits
// R15 - Integrators every bit, combs per decimation
package bsd_pkg;
   localparam int unsigned SYS_CLK_HZ = 40000000;
   // Modulator clock from the host divider
   localparam int unsigned MOD_CLK_MIN_HZ = 5000000;
   localparam int unsigned MOD_CLK_MAX_HZ = 21000000;
   localparam int unsigned MOD_DIV = 8;
   localparam int unsigned MOD_CLK_HZ = SYS_CLK_HZ / MOD_DIV;
   localparam int unsigned DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
   // Input level: signed, +/-32768 is absolute full scale
   localparam int unsigned LEVEL_W = 17;
   localparam int unsigned MOD_ACC_W = 24;
   localparam logic signed [MOD_ACC_W-1:0] MOD_FEEDBACK = 24'sh008000;
   // Integrator ceiling, far above any state a stable loop reaches
   localparam logic signed [MOD_ACC_W-1:0] MOD_INTEG_LIM = 24'sh200000;
   localparam logic signed [LEVEL_W-1:0] LEVEL_MAX = 17'sh08000;
   localparam logic signed [LEVEL_W-1:0] LEVEL_MIN = 17'sh18000;
   // Sinc3 receiver
   localparam int unsigned DEC_RATIO = 256;
   localparam int unsigned DEC_CNT_W = 8;
   localparam logic [DEC_CNT_W-1:0] DEC_LAST = 8'hff;
   localparam int unsigned SINC_ORDER = 3;
   localparam int unsigned DATA_SIZE = SINC_ORDER * DEC_CNT_W;
   localparam int unsigned SINC_W = DATA_SIZE + 1;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned WORD_LSB = DATA_SIZE - WORD_W;
   localparam logic [WORD_W-1:0] WORD_MAX = 16'hffff;
   localparam logic [WORD_W-1:0] WORD_MID = 16'h8000;
endpackage

// *** core/bsd_link_if.sv ***
// Two-wire link between modulator end and receiving host end.
// Assumes both ends are clocked by the same system clock in this model.
`timescale 1ns/1ps
interface bsd_link_if;
   logic modulator_clock_in;
   logic modulator_bit_out;
   modport dev (input modulator_clock_in, output modulator_bit_out);
   modport host (output modulator_clock_in, input modulator_bit_out);
endinterface // bsd_link_if

// *** core/bsd_modulator.sv ***
// Digital model of a second-order single-bit modulator end.
// Assumes the modulator clock arrives from the host as an unsynchronised pin.
`timescale 1ns/1ps
module bsd_modulator
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic signed [LEVEL_W-1:0] i_level,
   bsd_link_if.dev link
);
   logic clk_sync1;
   logic clk_sync2;
   logic clk_prev;
   logic bit_out;
   logic signed [MOD_ACC_W-1:0] integ1;
   logic signed [MOD_ACC_W-1:0] integ2;
   wire rise = clk_sync2 & ~clk_prev;
   // Clamp to absolute full scale
   wire logic signed [LEVEL_W-1:0] level_c = (i_level > LEVEL_MAX) ? LEVEL_MAX :
      (i_level < LEVEL_MIN) ? LEVEL_MIN : i_level;
   wire logic signed [MOD_ACC_W-1:0] level_x = MOD_ACC_W'(level_c);
   // Feedback from the bit now on the wire
   wire logic signed [MOD_ACC_W-1:0] fb = bit_out ? MOD_FEEDBACK : -MOD_FEEDBACK; // R1 R6
   // Full scale drives the integrators without end; hold them at a ceiling
   wire logic signed [MOD_ACC_W-1:0] sum1 = integ1 + level_x - fb;
   wire logic signed [MOD_ACC_W-1:0] next_integ1 = (sum1 > MOD_INTEG_LIM) ? MOD_INTEG_LIM :
      (sum1 < -MOD_INTEG_LIM) ? -MOD_INTEG_LIM : sum1; // R6
   wire logic signed [MOD_ACC_W-1:0] sum2 = integ2 + next_integ1 - fb;
   wire logic signed [MOD_ACC_W-1:0] next_integ2 = (sum2 > MOD_INTEG_LIM) ? MOD_INTEG_LIM :
      (sum2 < -MOD_INTEG_LIM) ? -MOD_INTEG_LIM : sum2; // R6
   // Ones density = 1/2 + level/65536: 25600 gives 89.06%, -25600 gives 10.94%
   wire next_bit = ~next_integ2[MOD_ACC_W-1]; // R1 R3 R4 R5

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clk_sync1 <= 1'b0;
         clk_sync2 <= 1'b0;
         clk_prev <= 1'b0;
      end else begin
         clk_sync1 <= link.modulator_clock_in; // R2
         clk_sync2 <= clk_sync1;
         clk_prev <= clk_sync2;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         integ1 <= '0;
         integ2 <= '0;
         bit_out <= 1'b0;
      end else if (rise) begin
         integ1 <= next_integ1;
         integ2 <= next_integ2;
         bit_out <= next_bit; // R12
      end
   end

   assign link.modulator_bit_out = bit_out;
endmodule // bsd_modulator

// *** testbench/bsd_chk.sv ***
// Checker for the link wires and the decimated word strobe.
// Assumes one system clock shared by both ends and an active-low reset.
`timescale 1ns/1ps
module bsd_chk
   import bsd_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic modulator_clock_in,
   input wire logic modulator_bit_out,
   input wire logic [WORD_W-1:0] o_word,
   input wire logic o_word_valid
);
   wire mc = modulator_clock_in;
   wire mb = modulator_bit_out;
   logic [11:0] gap;
   logic seen;
   // Cycles since the last word strobe
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
      if (!i_reset_n) {seen, gap} <= '0;
      else {seen, gap} <= {seen | o_word_valid, o_word_valid ? 12'h000 : gap + 12'h001};
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   clk_high_span_a: assert property ($rose(mc) |-> mc[*4] ##1 !mc)
      else $error("modulator clock high phase wrong");
   clk_low_span_a: assert property ($fell(mc) |-> !mc[*4] ##1 mc)
      else $error("modulator clock low phase wrong");
   bit_launch_a: assert property ($changed(mb) |-> $past(mc, 3) && !$past(mc, 4))
      else $error("stream bit changed off its launch point");
   bit_hold_a: assert property ($changed(mb) |=> $stable(mb)[*7])
      else $error("stream bit did not stand a full period");
   word_period_a: assert property (o_word_valid && seen |-> gap == 12'h7ff)
      else $error("word period is not 2048 cycles");
   word_change_a: assert property ($changed(o_word) |-> o_word_valid)
      else $error("word changed without strobe");
   valid_pulse_a: assert property (o_word_valid |=> !o_word_valid)
      else $error("word strobe longer than one cycle");
   valid_phase_a: assert property (o_word_valid |-> mc)
      else $error("word strobe outside clock high phase");
endmodule // bsd_chk

// *** testbench/tb_top.sv ***
// Bench: corner and random input levels, checks words and ones density.
// Assumes the link interface joins both ends on one 40 MHz clock.
`timescale 1ns/1ps
module tb_top;
   import bsd_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_reset_n = 1'b0;
   logic signed [LEVEL_W-1:0] i_level = '0;
   logic [WORD_W-1:0] o_word;
   logic o_word_valid;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   int ones = 0;
   int rises = 0;
   int lv[5] = '{0, 25600, -25600, 32768, -32768};
   bsd_link_if link();
   bsd_modulator i_bsd_modulator(.i_clk_sys, .i_reset_n, .i_level, .link(link));
   bsd_sinc3_host i_bsd_sinc3_host(.i_clk_sys, .i_reset_n, .o_word, .o_word_valid, .link(link));
   bsd_chk i_bsd_chk(.i_clk_sys, .i_reset_n, .modulator_clock_in(link.modulator_clock_in),
      .modulator_bit_out(link.modulator_bit_out), .o_word, .o_word_valid);
   initial forever #12.5 i_clk_sys = ~i_clk_sys;
   // Ones density seen at each modulator clock rise
   always @(posedge link.modulator_clock_in) begin
      ones += int'(link.modulator_bit_out);
      rises++;
   end
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 90000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   function automatic int clip(input int v, input int lo, input int hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction
   // Ideal settled code for a level
   function automatic int exp_word(input int l);
      return clip(32768 + l, 0, 65535);
   endfunction
   // Ideal count of ones among n bits for a level
   function automatic int exp_ones(input int l, input int n);
      return n * (clip(l, -32768, 32768) + 32768) / 65536;
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
      logic ok;
      ok = (got + tol >= exp) && (got <= exp + tol);
      total_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_word();
      do @(negedge i_clk_sys); while (o_word_valid !== 1'b1);
   endtask
   // Settle three words, then check the fourth and its bit density
   task automatic run_level(input int l);
      @(negedge i_clk_sys) i_level = l[LEVEL_W-1:0];
      repeat (3) wait_word();
      ones = 0;
      rises = 0;
      wait_word();
      cmp(o_word, exp_word(l), 64);
      cmp(ones, exp_ones(l, rises), 4);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      void'($urandom(35246));
      repeat (2) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      cmp(o_word, 16'h8000, 0);
      cmp(link.modulator_clock_in, 0, 0);
      i_reset_n = 1'b1;
      foreach (lv[k]) run_level(lv[k]);
      repeat (4) run_level(int'($urandom_range(51200)) - 25600);
      tally_and_finish();
   end
endmodule // tb_top
